// [common/gpcb_pkg.sv]
package gpcb_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_GPIO_5_3_CONFIG = 8'h42; // Pin 5.3 configuration
    localparam logic [7:0] OFS_GPIO_5_4_CONFIG = 8'h43; // Pin 5.4 configuration
    localparam logic [7:0] OFS_GPIO_5_5_CONFIG = 8'h44; // Pin 5.5 configuration
    localparam logic [7:0] OFS_GPIO_5_6_CONFIG = 8'h45; // Pin 5.6 configuration
    localparam logic [7:0] OFS_GPIO_5_7_CONFIG = 8'h46; // Pin 5.7 configuration
    localparam logic [7:0] OFS_GPIO_6_0_CONFIG = 8'h47; // Pin 6.0 configuration
    localparam logic [7:0] OFS_PIN_DATA = 8'h48;        // Pin data (coined)
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h49;      // Sticky events, read clears (coined)
    localparam logic [7:0] OFS_IRQ_MASK = 8'h4A;        // Event mask (coined)

    // ----------------------------------------
    // Configuration field positions
    // ----------------------------------------
    localparam int CFG_DIR_BIT = 0;    // 1 input, 0 output
    localparam int CFG_POL_BIT = 1;    // 1 inverts
    localparam int CFG_FUNC_LSB = 2;   // Function select low bit
    localparam int CFG_FUNC_MSB = 3;   // Function select high bit
    localparam int CFG_OD_BIT = 7;     // 1 open drain, 0 push pull
    localparam logic [7:0] CFG_WRITE_MASK = 8'h8F; // Bits 6:4 reserved
    localparam logic [7:0] CFG_RESET = 8'h01;      // Non-inverted push-pull input
    localparam logic [5:0] MASK_RESET = 6'h00;     // All events masked

    // ----------------------------------------
    // Function select codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        GPCB_FUNC_GPIO = 2'b00,
        GPCB_FUNC_LOW = 2'b01,
        GPCB_FUNC_ALT = 2'b10,
        GPCB_FUNC_RSVD = 2'b11
    } gpcb_func_t;
endpackage : gpcb_pkg

// [hw/gpcb_pin.sv]
`timescale 1ns/100ps
// ----------------------------------------
// One configurable pin: config register, pad control, input path
// ----------------------------------------
module gpcb_pin (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg,
    input wire logic data_out,
    input wire logic alt_out,
    input wire logic alt_out_sel,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pin_value,
    output logic pin_edge
);
    logic sync_a;   // First synchroniser stage, read only by sync_b
    logic sync_b;   // Second synchroniser stage
    logic sync_d;   // Delayed copy for edge detection
    logic is_input; // Direction bit
    logic invert;   // Polarity bit
    logic level;    // Level before polarity

    // ----------------------------------------
    // Configuration register
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= gpcb_pkg::CFG_RESET; // [RULE_12]
        end else if (cfg_we) begin
            cfg <= cfg_wdata & gpcb_pkg::CFG_WRITE_MASK; // [RULE_13]
        end
    end

    assign is_input = cfg[gpcb_pkg::CFG_DIR_BIT];
    assign invert = cfg[gpcb_pkg::CFG_POL_BIT];
    // Alternate output (indicator) overrides the data bit
    assign level = alt_out_sel ? alt_out : data_out;

    // ----------------------------------------
    // Pad drive: open drain only ever pulls low
    // ----------------------------------------
    always_comb begin
        pad_out = level ^ invert; // [RULE_02] [RULE_13]
        if (is_input && !alt_out_sel) begin
            pad_oe_n = 1'b1; // [RULE_01]
        end else if (cfg[gpcb_pkg::CFG_OD_BIT]) begin
            pad_oe_n = pad_out; // [RULE_03]
        end else begin
            pad_oe_n = 1'b0; // [RULE_03]
        end
    end

    // ----------------------------------------
    // Input synchroniser and either-edge detect
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            sync_a <= pad_in;
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    // Polarity-corrected value seen by software and by interrupt routing
    assign pin_value = sync_b ^ invert; // [RULE_02] [RULE_13]
    assign pin_edge = sync_b ^ sync_d; // [RULE_10]
endmodule : gpcb_pin

// [hw/gpcb_bank.sv]
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
// Functional notes
// RULE_01: bit 0 one is input, zero output
// RULE_02: bit 1 one inverts pin signal
// RULE_03: bit 7 one open drain, zero push-pull
// RULE_04: bits 3:2 select function, 00 plain GPIO
// RULE_05: pin 5.3 code 10 drives IRQ 7
// RULE_06: pin 5.4 code 10 drives IRQ 9
// RULE_07: pin 5.5 code 10 drives IRQ 10
// RULE_08: pin 5.6 code 10 drives IRQ 11
// RULE_09: pin 5.7 code 10 drives IRQ 15
// RULE_10: pin 6.0 code 10 either-edge interrupt four
// RULE_11: pin 6.0 code 01 first indicator, 11 reserved
// RULE_12: registers reset to 0x01
// RULE_13: reserved bits zero; polarity on both directions
module gpcb_bank #(
    parameter int NUM_PINS = 6 // Pins in this bank
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe_n,
    input wire logic indicator_out_first,
    output logic irq_line_7,
    output logic irq_line_9,
    output logic irq_line_10,
    output logic irq_line_11,
    output logic irq_line_15,
    output logic edge_irq_fourth,
    output logic irq
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0] cfg [NUM_PINS];          // Configuration registers
    logic [NUM_PINS-1:0] cfg_we;         // Per-register write strobes
    logic [NUM_PINS-1:0] data_out;       // Output data bits
    logic [NUM_PINS-1:0] pin_value;      // Polarity-corrected input levels
    logic [NUM_PINS-1:0] pin_edge;       // Either-edge pulses
    logic [NUM_PINS-1:0] alt_sel;        // Pin in alternate function 10
    logic [NUM_PINS-1:0] irq_status;     // Sticky events
    logic [NUM_PINS-1:0] irq_mask;       // 1 enables an event
    logic [NUM_PINS-1:0] event_pulse;    // Events this cycle
    logic [NUM_PINS-1:0] alt_out_sel;    // Drive pad from alternate source
    logic status_rd;                     // Status register is being read
    logic [7:0] next_rdata;              // Read mux

    // ----------------------------------------
    // Per-pin logic
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            logic [1:0] func;
            assign cfg_we[gi] = reg_wr && (reg_addr == gpcb_pkg::OFS_GPIO_5_3_CONFIG + 8'(gi));
            assign func = cfg[gi][gpcb_pkg::CFG_FUNC_MSB:gpcb_pkg::CFG_FUNC_LSB];
            assign alt_sel[gi] = (func == gpcb_pkg::GPCB_FUNC_ALT); // [RULE_04]
            // Only the last pin has an output-type alternate (indicator)
            assign alt_out_sel[gi] = (gi == NUM_PINS - 1)
                && (func == gpcb_pkg::GPCB_FUNC_LOW); // [RULE_11]
            gpcb_pin u_pin (
                .clock(clock),
                .arst_n(arst_n),
                .cfg_we(cfg_we[gi]),
                .cfg_wdata(reg_wdata),
                .cfg(cfg[gi]),
                .data_out(data_out[gi]),
                .alt_out(indicator_out_first),
                .alt_out_sel(alt_out_sel[gi]),
                .pad_in(pad_in[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe_n(pad_oe_n[gi]),
                .pin_value(pin_value[gi]),
                .pin_edge(pin_edge[gi])
            );
            // Edges count as events only while the pin serves an alternate input
            assign event_pulse[gi] = pin_edge[gi] && alt_sel[gi];
        end
    endgenerate

    // ----------------------------------------
    // Interrupt request routing
    // ----------------------------------------
    // Lines are level: the polarity-corrected pin state while code 10 holds.
    // Codes 01 and 11 on pins 5.3..5.7 leave the line low.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_line_7 <= 1'b0;
            irq_line_9 <= 1'b0;
            irq_line_10 <= 1'b0;
            irq_line_11 <= 1'b0;
            irq_line_15 <= 1'b0;
        end else begin
            irq_line_7 <= alt_sel[0] && pin_value[0];  // [RULE_05]
            irq_line_9 <= alt_sel[1] && pin_value[1];  // [RULE_06]
            irq_line_10 <= alt_sel[2] && pin_value[2]; // [RULE_07]
            irq_line_11 <= alt_sel[3] && pin_value[3]; // [RULE_08]
            irq_line_15 <= alt_sel[4] && pin_value[4]; // [RULE_09]
        end
    end

    // Either-edge interrupt: one-cycle pulse per transition of pin 6.0
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            edge_irq_fourth <= 1'b0;
        end else begin
            edge_irq_fourth <= alt_sel[NUM_PINS-1] && pin_edge[NUM_PINS-1]; // [RULE_10]
        end
    end

    // ----------------------------------------
    // Output data register
    // ----------------------------------------
    // Written as plain bits; polarity is applied at the pad
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= '0;
        end else if (reg_wr && reg_addr == gpcb_pkg::OFS_PIN_DATA) begin
            data_out <= reg_wdata[NUM_PINS-1:0];
        end
    end

    // ----------------------------------------
    // Interrupt mask
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask <= gpcb_pkg::MASK_RESET;
        end else if (reg_wr && reg_addr == gpcb_pkg::OFS_IRQ_MASK) begin
            irq_mask <= reg_wdata[NUM_PINS-1:0];
        end
    end

    // ----------------------------------------
    // Sticky status, cleared by read
    // ----------------------------------------
    // A new event in the read cycle survives: set wins over clear
    assign status_rd = reg_rd && (reg_addr == gpcb_pkg::OFS_IRQ_STATUS);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= '0;
        end else begin
            irq_status <= (status_rd ? '0 : irq_status) | event_pulse;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        next_rdata = 8'h00; // Unmapped offsets read zero
        for (int i = 0; i < NUM_PINS; i++) begin
            if (reg_addr == gpcb_pkg::OFS_GPIO_5_3_CONFIG + 8'(i)) begin
                next_rdata = cfg[i]; // [RULE_13]
            end
        end
        if (reg_addr == gpcb_pkg::OFS_PIN_DATA) begin
            // Inputs show the pin, outputs the data latch
            for (int i = 0; i < NUM_PINS; i++) begin
                next_rdata[i] = cfg[i][gpcb_pkg::CFG_DIR_BIT] ? pin_value[i] : data_out[i];
            end
        end else if (reg_addr == gpcb_pkg::OFS_IRQ_STATUS) begin
            next_rdata[NUM_PINS-1:0] = irq_status;
        end else if (reg_addr == gpcb_pkg::OFS_IRQ_MASK) begin
            next_rdata[NUM_PINS-1:0] = irq_mask;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : gpcb_bank

// [bench/gpcb_board.sv]
`timescale 1ns/100ps
// Board side of the pins: resolves each wire from bank drive and board level
module gpcb_board (
    input wire logic [5:0] pad_out,
    input wire logic [5:0] pad_oe_n,
    input wire logic [5:0] board_level,
    output logic [5:0] pad_in
);
    // Bank drive wins while enabled, else the board level shows
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & board_level);
endmodule : gpcb_board

// [bench/gpcb_bank_chk.sv]
`timescale 1ns/100ps
module gpcb_bank_chk #(
    parameter int NUM_PINS = 6
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [NUM_PINS-1:0] pad_in,
    input wire logic [NUM_PINS-1:0] pad_out,
    input wire logic [NUM_PINS-1:0] pad_oe_n,
    input wire logic irq_line_7,
    input wire logic edge_irq_fourth,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic [2:0] last_idx; // Pin of the previous access
    wire cfg_hit = (reg_addr >= 8'h42) && (reg_addr <= 8'h47); // Config window
    wire led_sel = (reg_addr == 8'h47) && (reg_wdata[3:2] == 2'b01); // Indicator forces drive
    // Remember which pin the last access aimed at
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            last_idx <= 3'h0;
        end else begin
            last_idx <= reg_addr[2:0] - 3'h2;
        end
    end
    sequence s_cfg_wr;
        reg_wr && cfg_hit;
    endsequence
    sequence s_wr_rd;
        s_cfg_wr ##1 (reg_rd && $stable(reg_addr));
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) > 8'h4A |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_reserved_zero: assert property ($past(reg_rd && cfg_hit) |-> reg_rdata[6:4] == 3'h0)
        else $error("reserved config bits not zero");
    chk_reset_state: assert property (
        $rose(arst_n) |-> &pad_oe_n && pad_out == '0 && !irq && !irq_line_7)
        else $error("state after reset wrong");
    chk_cfg_readback: assert property (
        s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & 8'h8F))
        else $error("config read back wrong");
    chk_dir_input: assert property (
        s_cfg_wr ##0 (reg_wdata[0] && !led_sel) |=> pad_oe_n[last_idx])
        else $error("input pin driven");
    chk_dir_output: assert property (
        s_cfg_wr ##0 (!reg_wdata[0] && !reg_wdata[7]) |=> !pad_oe_n[last_idx])
        else $error("push-pull output not driven");
    chk_od_no_high: assert property (
        s_cfg_wr ##0 (reg_wdata[7] && !led_sel)
        |=> pad_oe_n[last_idx] || !pad_out[last_idx])
        else $error("open drain drove high");
    chk_edge_cause: assert property (
        edge_irq_fourth |-> $past(pad_in[5], 2) != $past(pad_in[5], 3)
        || $past(pad_in[5], 3) != $past(pad_in[5], 4))
        else $error("edge pulse without pin change");
endmodule : gpcb_bank_chk
bind gpcb_bank gpcb_bank_chk #(.NUM_PINS(NUM_PINS)) i_gpcb_bank_chk (.*);

// [bench/gpcb_bank_bench.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module gpcb_bank_bench;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [5:0] board_level = 6'h00; // Levels the board puts on idle pins
    logic indicator_out_first = 1'b0;
    logic [5:0] pad_in, pad_out, pad_oe_n;
    logic irq_line_7, irq_line_9, irq_line_10, irq_line_11, irq_line_15, edge_irq_fourth, irq;
    wire [4:0] irq_vec = {irq_line_15, irq_line_11, irq_line_10, irq_line_9, irq_line_7};
    int fails = 0;
    int check_count = 0;
    logic [7:0] v;
    int n;
    always #12.5 clock = ~clock;
    gpcb_bank i_gpcb_bank (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .indicator_out_first(indicator_out_first), .irq_line_7(irq_line_7),
        .irq_line_9(irq_line_9), .irq_line_10(irq_line_10), .irq_line_11(irq_line_11),
        .irq_line_15(irq_line_15), .edge_irq_fourth(edge_irq_fourth), .irq(irq));
    gpcb_board i_gpcb_board (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .board_level(board_level), .pad_in(pad_in));
    // ----------------------------------------
    // Bus and timing helpers
    // ----------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task chk_rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata; // Data stands only this cycle
        `CHK("rdata", ex, v)
    endtask : chk_rd
    // Write then read the same offset with no idle cycle between the strobes
    task wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] ex);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        `CHK("rdata", ex, v)
    endtask : wr_rd
    task settle(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : settle
    task set_pin(input int i, input logic b); // Board level changes on a clock edge
        @(posedge clock);
        board_level[i] <= b;
    endtask : set_pin
    task count_edges; // Pulses within the synchroniser latency window
        n = 0;
        repeat (6) begin
            @(posedge clock);
            #1 n += int'(edge_irq_fourth === 1'b1);
        end
    endtask : count_edges
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        for (int i = 0; i < 6; i++) chk_rd(8'h42 + 8'(i), 8'h01);
        `CHK("oe_n", 6'h3F, pad_oe_n)
        wr_rd(8'h42, 8'hFF, 8'h8F);
        wr(8'h60, 8'hFF);
        chk_rd(8'h60, 8'h00);
        $display("test reset_fields done");
    endtask : t_reset
    task t_pad;
        wr(8'h48, 8'h01);
        wr(8'h42, 8'h00);
        settle(1);
        `CHK("oe_n0", 1'b0, pad_oe_n[0])
        `CHK("out0", 1'b1, pad_out[0])
        wr(8'h42, 8'h02);
        settle(1);
        `CHK("out0", 1'b0, pad_out[0])
        wr(8'h42, 8'h80);
        settle(1);
        `CHK("oe_n0", 1'b1, pad_oe_n[0])
        wr(8'h48, 8'h00);
        settle(1);
        `CHK("od_low", 2'b00, {pad_oe_n[0], pad_out[0]})
        wr(8'h42, 8'h03);
        set_pin(0, 1'b1);
        settle(4);
        chk_rd(8'h48, 8'h00);
        set_pin(0, 1'b0);
        $display("test pad_control done");
    endtask : t_pad
    task t_irq_lines; // Each pin alone on its own request line, then inverted
        for (int i = 0; i < 5; i++) begin
            wr(8'h42 + 8'(i), 8'h09);
            set_pin(i, 1'b1);
            settle(5);
            `CHK("irq_vec", 5'h01 << i, irq_vec)
            wr(8'h42 + 8'(i), 8'h0B);
            settle(4);
            `CHK("irq_vec", 5'h00, irq_vec)
            set_pin(i, 1'b0);
            wr(8'h42 + 8'(i), 8'h01);
        end
        $display("test irq_lines done");
    endtask : t_irq_lines
    task t_edge;
        // Edges seen while pins 5.3..5.7 served their request lines are still sticky
        chk_rd(8'h49, 8'h1F);
        wr(8'h4A, 8'h20);
        wr(8'h47, 8'h09);
        settle(4);
        set_pin(5, 1'b1);
        count_edges;
        `CHK("rise", 1, n)
        `CHK("irq", 1'b1, irq)
        chk_rd(8'h49, 8'h20);
        settle(1);
        `CHK("irq", 1'b0, irq)
        set_pin(5, 1'b0);
        count_edges;
        `CHK("fall", 1, n)
        wr(8'h4A, 8'h00);
        settle(1);
        `CHK("masked", 1'b0, irq)
        chk_rd(8'h49, 8'h20);
        $display("test edge_irq done");
    endtask : t_edge
    task t_indicator;
        wr(8'h47, 8'h05);
        @(posedge clock);
        indicator_out_first <= 1'b1;
        settle(1);
        `CHK("led_on", 2'b01, {pad_oe_n[5], pad_out[5]})
        @(posedge clock);
        indicator_out_first <= 1'b0;
        settle(1);
        `CHK("led_off", 1'b0, pad_out[5])
        wr(8'h47, 8'h0D);
        settle(1);
        `CHK("rsvd_oe", 1'b1, pad_oe_n[5])
        set_pin(5, 1'b1);
        count_edges;
        `CHK("rsvd_edge", 0, n)
        $display("test indicator done");
    endtask : t_indicator
    // ----------------------------------------
    // Verdict
    // ----------------------------------------
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    // Main sequence after the 16-cycle reset
    initial begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        t_reset;
        t_pad;
        t_irq_lines;
        t_edge;
        t_indicator;
        end_of_test;
    end
    // Watchdog: the tests need well under 1000 cycles
    initial begin
        #100000;
        fails++;
        end_of_test;
    end
endmodule : gpcb_bank_bench
